// file: logic/dct_consts.vh
// constants for the dual carrier counter/timer: register offsets, field positions, load values
`ifndef DCT_CONSTS_VH
`define DCT_CONSTS_VH

// register offsets (one byte each on the plain register port)
`define DCT_ADDR_NARROW_CTRL   8'h00
`define DCT_ADDR_SHARED_CTRL   8'h01
`define DCT_ADDR_WIDE_CTRL     8'h02
`define DCT_ADDR_ENABLE_SYNC   8'h03
`define DCT_ADDR_LOW_HOLD      8'h04
`define DCT_ADDR_HIGH_HOLD     8'h05
`define DCT_ADDR_WIDE_HOLD_LO  8'h06
`define DCT_ADDR_WIDE_HOLD_HI  8'h07
`define DCT_ADDR_POS_CAPTURE   8'h08
`define DCT_ADDR_NEG_CAPTURE   8'h09
`define DCT_ADDR_WIDE_CAP_LO   8'h0A
`define DCT_ADDR_WIDE_CAP_HI   8'h0B

// narrow counter control fields
`define DCT_NC_SINGLE_PASS     6
`define DCT_NC_TIMEOUT         5
`define DCT_NC_PRESCALE_HI     4
`define DCT_NC_PRESCALE_LO     3
`define DCT_NC_CAPTURE_IE      2
`define DCT_NC_TIMEOUT_IE      1

// shared control fields
`define DCT_SC_DEMOD_MODE      7
`define DCT_SC_NEG_EDGE_EN     3
`define DCT_SC_POS_EDGE_EN     2
`define DCT_SC_INIT_LEVEL      1
`define DCT_SC_POS_STATUS      1
`define DCT_SC_NEG_STATUS      0

// wide counter control fields
`define DCT_WC_EDGE_ONCE       6
`define DCT_WC_TIMEOUT         5
`define DCT_WC_CLOCK_SEL       4
`define DCT_WC_CAPTURE_IE      3
`define DCT_WC_TIMEOUT_IE      2
`define DCT_WC_OUTPUT_SEL      1
`define DCT_WC_SINGLE_PASS     0

// enable/sync control fields
`define DCT_ES_WIDE_EN         7
`define DCT_ES_NARROW_EN       6
`define DCT_ES_SYNC            5
`define DCT_ES_RESERVED_READ   5'h1F

// counter load, terminal-count and reset values
`define DCT_NARROW_RELOAD      8'hFF
`define DCT_WIDE_RELOAD        16'hFFFF
`define DCT_NARROW_TERM        8'h01
`define DCT_WIDE_TERM          16'h0001
`define DCT_BYTE_RESET         8'h00
`define DCT_WORD_RESET         16'h0000

`endif

// file: logic/dct_counter_timer.v
// dual carrier counter/timer: 8-bit carrier/demod counter, 16-bit counter, shared controls
`include "dct_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module dct_counter_timer (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [7:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWr,
    input  wire       regRd,
    output reg  [7:0] regRdata,
    input  wire       demodPin,
    input  wire       portOutValue,
    output reg        sharedOutputPin,
    output reg        narrowCounterOutput,
    output reg        wideCounterOutput,
    output reg        narrowIrq,
    output reg        wideIrq
);

    // register fields
    reg        singlePass;
    reg [1:0]  narrowPrescale;
    reg        narrowCapIe;
    reg        narrowToutIe;
    reg        narrowTimeoutFlag;
    reg        demodMode;
    reg        negEdgeEn;
    reg        posEdgeEn;
    reg        initLevel;
    reg        posStatus;
    reg        negStatus;
    reg        edgeOnce;
    reg        wideTimeoutFlag;
    reg        wideClockSel;
    reg        wideCapIe;
    reg        wideToutIe;
    reg        outputSel;
    reg        wideSinglePass;
    reg        syncMode;
    reg [7:0]  lowHold;
    reg [7:0]  highHold;
    reg [15:0] wideHold;
    reg [7:0]  posCapture;
    reg [7:0]  negCapture;
    reg [15:0] wideCapture;
    // counter state
    reg [7:0]  narrowCnt;
    reg        narrowRun;
    reg        narrowWaitSync;
    reg        narrowFirstTerm;
    reg [15:0] wideCnt;
    reg        wideRun;
    reg        wideEdgeSeen;
    // divider, pin synchroniser, edge history
    reg [2:0]  divCnt;
    reg        demodMeta;
    reg        demodSync;
    reg        demodPrev;
    reg        wideSigPrev;
    // write decodes
    wire wrNarrowCtrl = regWr && (regAddr == `DCT_ADDR_NARROW_CTRL);
    wire wrSharedCtrl = regWr && (regAddr == `DCT_ADDR_SHARED_CTRL);
    wire wrWideCtrl   = regWr && (regAddr == `DCT_ADDR_WIDE_CTRL);
    wire wrEnableSync = regWr && (regAddr == `DCT_ADDR_ENABLE_SYNC);
    // counter clock enables from one free-running divider
    reg  narrowTick;
    always @* begin
        case (narrowPrescale)
            2'b00:   narrowTick = 1'b1;
            2'b01:   narrowTick = divCnt[0];
            2'b10:   narrowTick = &divCnt[1:0];
            default: narrowTick = &divCnt;
        endcase
    end
    wire wideTick = wideClockSel ? (&divCnt) : 1'b1;
    // demod input edges, seen on the second synchroniser stage only
    wire riseEdge = demodSync & ~demodPrev;
    wire fallEdge = ~demodSync & demodPrev;
    wire posHit   = riseEdge & posEdgeEn;
    wire negHit   = fallEdge & negEdgeEn;
    // reference for sync: demodulated input in demod mode, wide output otherwise
    wire wideSignal = demodMode ? demodSync : wideCounterOutput;
    wire wideChange = wideSignal ^ wideSigPrev;
    // narrow counter events
    wire startNarrow  = wrEnableSync & regWdata[`DCT_ES_NARROW_EN] & ~narrowRun;
    wire stopNarrow   = wrEnableSync & ~regWdata[`DCT_ES_NARROW_EN];
    wire narrowActive = narrowRun & ~narrowWaitSync;
    wire narrowStep   = narrowActive & narrowTick;
    wire narrowTerm   = narrowStep & (narrowCnt == `DCT_NARROW_TERM);
    wire capPos       = demodMode & narrowActive & posHit;
    wire capNeg       = demodMode & narrowActive & negHit;
    // first modulo-N terminal only toggles; later ones and single-pass flag
    wire narrowToutSet = (~demodMode & narrowTerm & (singlePass | ~narrowFirstTerm))
                       | (demodMode & narrowTerm);

    // wide counter events
    wire startWide = wrEnableSync & regWdata[`DCT_ES_WIDE_EN] & ~wideRun;
    wire stopWide  = wrEnableSync & ~regWdata[`DCT_ES_WIDE_EN];
    wire wideStep  = wideRun & wideTick;
    wire wideTerm  = wideStep & (wideCnt == `DCT_WIDE_TERM);
    wire wideCap   = demodMode & wideRun & (posHit | negHit)
                   & ~(edgeOnce & wideEdgeSeen);

    // divider and synchroniser
    always @(posedge clk) begin
        if (!rst_n) begin
            divCnt      <= 3'b000;
            demodMeta   <= 1'b0;
            demodSync   <= 1'b0;
            demodPrev   <= 1'b0;
            wideSigPrev <= 1'b0;
        end else begin
            divCnt      <= divCnt + 3'b001;
            demodMeta   <= demodPin;
            demodSync   <= demodMeta;
            demodPrev   <= demodSync;
            wideSigPrev <= wideSignal;
        end
    end

    // software-written fields and sticky flags
    always @(posedge clk) begin
        if (!rst_n) begin
            singlePass        <= 1'b0;
            narrowPrescale    <= 2'b00;
            narrowCapIe       <= 1'b0;
            narrowToutIe      <= 1'b0;
            narrowTimeoutFlag <= 1'b0;
            demodMode         <= 1'b0;
            negEdgeEn         <= 1'b0;
            posEdgeEn         <= 1'b0;
            initLevel         <= 1'b0;
            posStatus         <= 1'b0;
            negStatus         <= 1'b0;
            edgeOnce          <= 1'b0;
            wideTimeoutFlag   <= 1'b0;
            wideClockSel      <= 1'b0;
            wideCapIe         <= 1'b0;
            wideToutIe        <= 1'b0;
            outputSel         <= 1'b0;
            wideSinglePass    <= 1'b0;
            syncMode          <= 1'b0;
            lowHold           <= `DCT_BYTE_RESET;
            highHold          <= `DCT_BYTE_RESET;
            wideHold          <= `DCT_WORD_RESET;
        end else begin
            if (wrNarrowCtrl) begin
                singlePass     <= regWdata[`DCT_NC_SINGLE_PASS];
                narrowPrescale <= regWdata[`DCT_NC_PRESCALE_HI:`DCT_NC_PRESCALE_LO];
                narrowCapIe    <= regWdata[`DCT_NC_CAPTURE_IE];
                narrowToutIe   <= regWdata[`DCT_NC_TIMEOUT_IE];
            end
            // an event in the clearing cycle still sets the flag
            narrowTimeoutFlag <= (narrowTimeoutFlag
                                 & ~(wrNarrowCtrl & regWdata[`DCT_NC_TIMEOUT]))
                                 | narrowToutSet;
            if (wrSharedCtrl) begin
                demodMode <= regWdata[`DCT_SC_DEMOD_MODE];
                negEdgeEn <= regWdata[`DCT_SC_NEG_EDGE_EN];
                posEdgeEn <= regWdata[`DCT_SC_POS_EDGE_EN];
            end
            // low bits are initial level in transmit, edge status in demod
            if (wrSharedCtrl && !demodMode) begin
                initLevel <= regWdata[`DCT_SC_INIT_LEVEL];
            end
            posStatus <= (posStatus & ~(wrSharedCtrl & demodMode
                         & regWdata[`DCT_SC_POS_STATUS])) | capPos;
            negStatus <= (negStatus & ~(wrSharedCtrl & demodMode
                         & regWdata[`DCT_SC_NEG_STATUS])) | capNeg;
            if (wrWideCtrl) begin
                edgeOnce       <= regWdata[`DCT_WC_EDGE_ONCE];
                wideClockSel   <= regWdata[`DCT_WC_CLOCK_SEL];
                wideCapIe      <= regWdata[`DCT_WC_CAPTURE_IE];
                wideToutIe     <= regWdata[`DCT_WC_TIMEOUT_IE];
                outputSel      <= regWdata[`DCT_WC_OUTPUT_SEL];
                wideSinglePass <= regWdata[`DCT_WC_SINGLE_PASS];
            end
            wideTimeoutFlag <= (wideTimeoutFlag
                               & ~(wrWideCtrl & regWdata[`DCT_WC_TIMEOUT]))
                               | wideTerm;
            if (wrEnableSync) begin
                syncMode <= regWdata[`DCT_ES_SYNC];
            end
            // hold writes never touch the live count, only the next reload
            if (regWr && (regAddr == `DCT_ADDR_LOW_HOLD)) begin
                lowHold <= regWdata;
            end
            if (regWr && (regAddr == `DCT_ADDR_HIGH_HOLD)) begin
                highHold <= regWdata;
            end
            if (regWr && (regAddr == `DCT_ADDR_WIDE_HOLD_LO)) begin
                wideHold[7:0] <= regWdata;
            end
            if (regWr && (regAddr == `DCT_ADDR_WIDE_HOLD_HI)) begin
                wideHold[15:8] <= regWdata;
            end
        end
    end

    // narrow counter
    always @(posedge clk) begin
        if (!rst_n) begin
            narrowCnt           <= `DCT_BYTE_RESET;
            narrowRun           <= 1'b0;
            narrowWaitSync      <= 1'b0;
            narrowFirstTerm     <= 1'b0;
            narrowCounterOutput <= 1'b0;
            posCapture          <= `DCT_BYTE_RESET;
            negCapture          <= `DCT_BYTE_RESET;
            narrowIrq           <= 1'b0;
        end else begin
            narrowIrq <= (narrowToutSet & narrowToutIe)
                       | ((capPos | capNeg) & narrowCapIe);
            if (capPos) begin
                posCapture <= narrowCnt;
            end
            if (capNeg) begin
                negCapture <= narrowCnt;
            end
            if (startNarrow) begin
                narrowRun           <= 1'b1;
                narrowWaitSync      <= regWdata[`DCT_ES_SYNC];
                narrowFirstTerm     <= 1'b1;
                narrowCounterOutput <= initLevel;
                if (demodMode) begin
                    narrowCnt <= `DCT_NARROW_RELOAD;
                end else begin
                    narrowCnt <= initLevel ? highHold : lowHold;
                end
            end else if (stopNarrow) begin
                narrowRun <= 1'b0;
            end else if (narrowRun && narrowWaitSync) begin
                // carrier starts on a reference edge, so its first pulse is whole
                if (wideChange) begin
                    narrowWaitSync <= 1'b0;
                end
            end else if (capPos || capNeg) begin
                narrowCnt <= `DCT_NARROW_RELOAD;
            end else if (narrowStep) begin
                if (demodMode) begin
                    // reaching 0 flags a timeout; the next step wraps to FFH
                    narrowCnt <= narrowCnt - 8'h01;
                end else if (narrowTerm) begin
                    narrowCounterOutput <= ~narrowCounterOutput;
                    narrowFirstTerm     <= 1'b0;
                    if (singlePass) begin
                        narrowCnt <= `DCT_BYTE_RESET;
                        narrowRun <= 1'b0;
                    end else begin
                        // new level 0 takes low hold, new level 1 high hold
                        narrowCnt <= narrowCounterOutput ? lowHold : highHold;
                    end
                end else begin
                    // a start value of 0 steps to FFH, a 256-step period
                    narrowCnt <= narrowCnt - 8'h01;
                end
            end
        end
    end

    // wide counter
    always @(posedge clk) begin
        if (!rst_n) begin
            wideCnt           <= `DCT_WORD_RESET;
            wideRun           <= 1'b0;
            wideEdgeSeen      <= 1'b0;
            wideCounterOutput <= 1'b0;
            wideCapture       <= `DCT_WORD_RESET;
            wideIrq           <= 1'b0;
        end else begin
            wideIrq <= (wideTerm & wideToutIe) | (wideCap & wideCapIe);
            if (startWide) begin
                wideRun      <= 1'b1;
                wideEdgeSeen <= 1'b0;
                wideCnt      <= demodMode ? `DCT_WIDE_RELOAD : wideHold;
            end else if (stopWide) begin
                wideRun <= 1'b0;
            end else if (wideCap) begin
                wideCapture  <= wideCnt;
                wideCnt      <= `DCT_WIDE_RELOAD;
                wideEdgeSeen <= 1'b1;
            end else if (wideStep) begin
                if (!demodMode && wideTerm) begin
                    wideCounterOutput <= ~wideCounterOutput;
                    if (wideSinglePass) begin
                        wideCnt <= `DCT_WORD_RESET;
                        wideRun <= 1'b0;
                    end else begin
                        wideCnt <= wideHold;
                    end
                end else begin
                    wideCnt <= wideCnt - 16'h0001;
                end
            end
        end
    end

    // shared pin: registered so it never glitches on a select change
    always @(posedge clk) begin
        if (!rst_n) begin
            sharedOutputPin <= 1'b0;
        end else begin
            sharedOutputPin <= outputSel ? wideCounterOutput : portOutValue;
        end
    end

    // read port: data in the cycle after the strobe, zero for unmapped offsets
    always @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= `DCT_BYTE_RESET;
        end else if (regRd) begin
            case (regAddr)
                `DCT_ADDR_NARROW_CTRL:
                    regRdata <= {1'b0, singlePass, narrowTimeoutFlag, narrowPrescale,
                                 narrowCapIe, narrowToutIe, 1'b0};
                `DCT_ADDR_SHARED_CTRL:
                    regRdata <= {demodMode, 3'b000, negEdgeEn, posEdgeEn,
                                 demodMode ? posStatus : initLevel,
                                 demodMode ? negStatus : 1'b0};
                `DCT_ADDR_WIDE_CTRL:
                    regRdata <= {1'b0, edgeOnce, wideTimeoutFlag, wideClockSel,
                                 wideCapIe, wideToutIe, outputSel, wideSinglePass};
                `DCT_ADDR_ENABLE_SYNC:
                    regRdata <= {wideRun, narrowRun, syncMode,
                                 `DCT_ES_RESERVED_READ};
                `DCT_ADDR_LOW_HOLD:     regRdata <= lowHold;
                `DCT_ADDR_HIGH_HOLD:    regRdata <= highHold;
                `DCT_ADDR_WIDE_HOLD_LO: regRdata <= wideHold[7:0];
                `DCT_ADDR_WIDE_HOLD_HI: regRdata <= wideHold[15:8];
                `DCT_ADDR_POS_CAPTURE:  regRdata <= posCapture;
                `DCT_ADDR_NEG_CAPTURE:  regRdata <= negCapture;
                `DCT_ADDR_WIDE_CAP_LO:  regRdata <= wideCapture[7:0];
                `DCT_ADDR_WIDE_CAP_HI:  regRdata <= wideCapture[15:8];
                default:                regRdata <= `DCT_BYTE_RESET;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: testbench/dct_counter_timer_checker.sv
// port-level assertions for the dual carrier counter/timer
`include "dct_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module dct_counter_timer_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    input wire logic       demodPin,
    input wire logic       portOutValue,
    input wire logic       sharedOutputPin,
    input wire logic       narrowCounterOutput,
    input wire logic       wideCounterOutput,
    input wire logic       narrowIrq,
    input wire logic       wideIrq
);
    // control shadows rebuilt from writes; single-pass self-stop is not tracked
    logic [7:0] nc, sc, wc;
    logic       run, startD, prevOut;
    logic [1:0] tog;
    wire        start = regWr && regAddr == `DCT_ADDR_ENABLE_SYNC && regWdata[6] && !run;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk) begin
        startD  <= start;
        prevOut <= narrowCounterOutput;
        if (regWr && regAddr == `DCT_ADDR_NARROW_CTRL) nc <= regWdata;
        if (regWr && regAddr == `DCT_ADDR_SHARED_CTRL) sc <= regWdata;
        if (regWr && regAddr == `DCT_ADDR_WIDE_CTRL) wc <= regWdata;
        if (regWr && regAddr == `DCT_ADDR_ENABLE_SYNC) run <= regWdata[6];
        // toggles seen since the last start, saturating
        if (startD) tog <= 2'd0;
        else if (narrowCounterOutput != prevOut && tog != 2'd3) tog <= tog + 2'd1;
        if (!rst_n) begin
            nc  <= 8'h00;
            sc  <= 8'h00;
            wc  <= 8'h00;
            run <= 1'b0;
            tog <= 2'd0;
        end
    end
    a_reserved_ones: assert property (regRd && regAddr == `DCT_ADDR_ENABLE_SYNC |=>
        regRdata[4:0] == `DCT_ES_RESERVED_READ) else $error("reserved bits not all ones");
    a_shared_pin: assert property (sharedOutputPin ==
        ($past(wc[1]) ? $past(wideCounterOutput) : $past(portOutValue)))
        else $error("shared pin wrong source");
    a_start_level: assert property (start && !sc[7] |=>
        narrowCounterOutput == sc[1]) else $error("start level wrong");
    a_stop_hold: assert property (!run && !$past(run) |->
        $stable(narrowCounterOutput)) else $error("stopped carrier moved");
    a_first_quiet: assert property (narrowIrq && !sc[7] && !nc[6] |->
        tog != 2'd0) else $error("irq on first modulo terminal");
    a_narrow_ie: assert property (narrowIrq |-> $past(nc[1]) || $past(nc[2]))
        else $error("narrow irq while masked");
    a_wide_ie: assert property (wideIrq |-> $past(wc[2]) || $past(wc[3]))
        else $error("wide irq while masked");
    a_narrow_pulse: assert property (narrowIrq |=> !narrowIrq)
        else $error("narrow irq longer than one cycle");
    a_wide_pulse: assert property (wideIrq |=> !wideIrq)
        else $error("wide irq longer than one cycle");
endmodule
bind dct_counter_timer dct_counter_timer_checker chk (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .demodPin(demodPin), .portOutValue(portOutValue),
    .sharedOutputPin(sharedOutputPin), .narrowCounterOutput(narrowCounterOutput),
    .wideCounterOutput(wideCounterOutput), .narrowIrq(narrowIrq), .wideIrq(wideIrq));
`default_nettype wire

// file: testbench/dct_counter_timer_tb.sv
// self-checking bench for the dual carrier counter/timer
`include "dct_consts.vh"
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, exp, got) begin nChecks++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module dct_counter_timer_tb;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic       demodPin = 1'b0;
    logic       portOutValue = 1'b0;
    wire  [7:0] regRdata;
    wire        sharedOutputPin, narrowCounterOutput, wideCounterOutput, narrowIrq, wideIrq;
    logic [7:0] rd, pos;
    int         errors = 0, nChecks = 0, cycles = 0, nIrqN = 0, nIrqW = 0;
    int         gaps[3] = '{5, 10, 30};
    int         wCnt, nCnt;
    logic       wOut, wTog, nWait, nOut, portPrev;
    dct_counter_timer dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .demodPin(demodPin),
        .portOutValue(portOutValue), .sharedOutputPin(sharedOutputPin),
        .narrowCounterOutput(narrowCounterOutput), .wideCounterOutput(wideCounterOutput),
        .narrowIrq(narrowIrq), .wideIrq(wideIrq));
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (rst_n) portOutValue <= 1'($urandom);
        portPrev <= portOutValue;
        if (cycles == 5000) begin
            errors++;
            testDone();
        end
    end
    // interrupt pulses counted off the edge so they never race the outputs
    always @(negedge clk) begin
        nIrqN += int'(narrowIrq === 1'b1);
        nIrqW += int'(wideIrq === 1'b1);
    end
    task automatic testDone;
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask
    // cycle model of the carrier; hold 0 wraps through FF, so it lasts 256 cycles
    task automatic carrier(input int lo, input int hi, input logic init, input logic sp,
                           input int n);
        int   cnt;
        logic out, first, act, irqExp;
        wr(`DCT_ADDR_LOW_HOLD, 8'(lo));
        wr(`DCT_ADDR_HIGH_HOLD, 8'(hi));
        wr(`DCT_ADDR_SHARED_CTRL, {6'h00, init, 1'b0});
        wr(`DCT_ADDR_NARROW_CTRL, {1'b0, sp, 6'h02});
        wr(`DCT_ADDR_ENABLE_SYNC, 8'h40);
        first = 1'b1;
        act = 1'b1;
        for (int k = 1; k <= n; k++) begin
            @(negedge clk);
            irqExp = 1'b0;
            if (k == 1) begin
                out = init;
                cnt = init ? hi : lo;
            end else if (act && cnt == 1) begin
                out = !out;
                irqExp = sp || !first;
                first = 1'b0;
                act = !sp;
                cnt = out ? hi : lo;
            end else if (act) begin
                cnt = (cnt + 255) % 256;
            end
            `CHECK("narrow output", out, narrowCounterOutput)
            `CHECK("narrow irq", irqExp, narrowIrq)
            `CHECK("shared pin", portPrev, sharedOutputPin)
        end
        rdc(`DCT_ADDR_ENABLE_SYNC, rd);
        `CHECK("run state", sp ? 8'h1F : 8'h5F, rd)
        wr(`DCT_ADDR_ENABLE_SYNC, 8'h00);
        rdc(`DCT_ADDR_NARROW_CTRL, rd);
        `CHECK("timeout flag", {1'b0, sp, 6'h22}, rd)
        wr(`DCT_ADDR_NARROW_CTRL, rd);
        rdc(`DCT_ADDR_NARROW_CTRL, rd);
        `CHECK("timeout cleared", {1'b0, sp, 6'h02}, rd)
    endtask
    initial begin
        void'($urandom(32'h9A76));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`DCT_ADDR_ENABLE_SYNC, rd);
        `CHECK("enable sync reset", 8'h1F, rd)
        wr(`DCT_ADDR_ENABLE_SYNC, 8'h20);
        rdc(`DCT_ADDR_ENABLE_SYNC, rd);
        `CHECK("sync set", 8'h3F, rd)
        wr(`DCT_ADDR_ENABLE_SYNC, 8'h00);
        rdc(8'h3C, rd);
        `CHECK("unmapped read", 8'h00, rd)
        carrier(2, 3, 1'b0, 1'b0, 40);
        carrier(2 + $urandom % 6, 2 + $urandom % 6, 1'b1, 1'b0, 60);
        carrier(0, 2, 1'b0, 1'b0, 270);
        carrier(3, 4, 1'b0, 1'b1, 20);
        // demodulation: both edges captured, wide counter takes only the first
        wr(`DCT_ADDR_SHARED_CTRL, 8'h8C);
        wr(`DCT_ADDR_NARROW_CTRL, 8'h04);
        wr(`DCT_ADDR_WIDE_CTRL, 8'h48);
        nIrqN = 0;
        nIrqW = 0;
        wr(`DCT_ADDR_ENABLE_SYNC, 8'hC0);
        foreach (gaps[i]) begin
            repeat (gaps[i]) @(posedge clk);
            demodPin <= !demodPin;
        end
        repeat (300) @(posedge clk);
        wr(`DCT_ADDR_ENABLE_SYNC, 8'h00);
        `CHECK("capture irqs", 3, nIrqN)
        `CHECK("wide capture irqs", 1, nIrqW)
        rdc(`DCT_ADDR_POS_CAPTURE, pos);
        rdc(`DCT_ADDR_NEG_CAPTURE, rd);
        `CHECK("capture gap", 8'd20, 8'(rd - pos))
        rdc(`DCT_ADDR_SHARED_CTRL, rd);
        `CHECK("edge status", 8'h8F, rd)
        rdc(`DCT_ADDR_NARROW_CTRL, rd);
        `CHECK("demod timeout", 8'h24, rd)
        // wide transmit drives the shared pin; narrow starts in sync with it
        wr(`DCT_ADDR_SHARED_CTRL, 8'h00);
        wr(`DCT_ADDR_WIDE_HOLD_LO, 8'h05);
        wr(`DCT_ADDR_WIDE_HOLD_HI, 8'h00);
        wr(`DCT_ADDR_WIDE_CTRL, 8'h06);
        nIrqW = 0;
        // narrow holds are still 3 low, 4 high from the single-pass run
        wr(`DCT_ADDR_ENABLE_SYNC, 8'hE0);
        wCnt = 5;
        wOut = 1'b0;
        wTog = 1'b0;
        nWait = 1'b1;
        nCnt = 3;
        nOut = 1'b0;
        for (int k = 1; k <= 40; k++) begin
            @(negedge clk);
            `CHECK("shared pin", wOut, sharedOutputPin)
            if (k > 1) begin
                // narrow leaves its wait one cycle after the wide output moves
                if (nWait) begin
                    nWait = !wTog;
                end else if (nCnt == 1) begin
                    nOut = !nOut;
                    nCnt = nOut ? 4 : 3;
                end else begin
                    nCnt = nCnt - 1;
                end
                wTog = (wCnt == 1);
                wOut = wOut ^ wTog;
                wCnt = wTog ? 5 : wCnt - 1;
            end
            `CHECK("wide output", wOut, wideCounterOutput)
            `CHECK("wide irq", wTog, wideIrq)
            `CHECK("synced carrier", nOut, narrowCounterOutput)
        end
        rdc(`DCT_ADDR_ENABLE_SYNC, rd);
        `CHECK("wide run", 8'hFF, rd)
        wr(`DCT_ADDR_ENABLE_SYNC, 8'h00);
        `CHECK("wide irqs", 1'b1, nIrqW >= 4)
        rdc(`DCT_ADDR_WIDE_CTRL, rd);
        `CHECK("wide timeout", 8'h26, rd)
        wr(`DCT_ADDR_WIDE_CTRL, rd);
        rdc(`DCT_ADDR_WIDE_CTRL, rd);
        `CHECK("wide timeout cleared", 8'h06, rd)
        testDone();
    end
endmodule
`default_nettype wire
